// ---- psr_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_far_end
  (
  input  wire logic                   CLK,
  input  wire logic                   RESETN,
  input  wire logic                   ARM,
  input  wire psr_pkg::psr_stage_type FAULT,
  input  wire psr_pkg::psr_route_type ROUTE,
  output var  psr_pkg::psr_stage_type STAGE,
  output var  logic                   DUE
  );
  import psr_pkg::*;
  // stage contacts follow the fault a clock late
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      STAGE <= '0;
    else
      STAGE <= FAULT;
  // once started, the reclose sequence holds due until disarmed
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      DUE <= 1'b0;
    else
      DUE <= ARM & (DUE | ROUTE.reclose_start_in_a | ROUTE.reclose_start_in_b);
endmodule
`default_nettype wire

// ---- psr_pkg.sv ----
`default_nettype none
package psr_pkg;

  // switch positions, switch n sits at vector index n-1
  localparam int ROUTE_LO_OC_START_ALARM3 = 0;
  localparam int ROUTE_OC_TRIP_ALARM1     = 1;
  localparam int ROUTE_LO_EF_TRIP_MAIN    = 2;
  localparam int ROUTE_TRIP_TO_ALARM1     = 6;
  localparam int ROUTE_TRIP_TO_ALARM2     = 7;
  localparam int LINK_LO_OC_START_B       = 0;
  localparam int LINK_HI_OC_START_B       = 1;
  localparam int LINK_HI_OC_START_A       = 2;
  localparam int LINK_BLK1_LO_OC          = 3;
  localparam int LINK_BLK1_HI_OC          = 4;
  localparam int LINK_BLK2_LO_OC          = 5;
  localparam int LINK_BLK2_HI_OC          = 6;

  localparam logic [7:0] ROUTE_DEFAULT = 8'h07;
  localparam logic [7:0] LINK_DEFAULT  = 8'h05;

  // output codes
  localparam int          NUM_OBJECTS     = 6;
  localparam logic [7:0]  CODE_CFG_BASE   = 8'h14;
  localparam logic [7:0]  CODE_DIRECT_OFS = 8'hc8;
  localparam logic [7:0]  CODE_FIFTH      = 8'h28;
  localparam logic [7:0]  CODE_SIXTH      = 8'h29;
  localparam logic [7:0]  CODE_SPAN       = 8'h0c;

  // alarm delay timing
  localparam int ALARM_DELAY_MS     = 40;
  localparam int CLK_MHZ            = 200;
  localparam int ALARM_DELAY_CYCLES = ALARM_DELAY_MS * 1000 * CLK_MHZ;
  localparam int DELAY_CNT_W        = 23;

  typedef struct packed {
    logic lo_oc_start;
    logic lo_oc_trip;
    logic hi_oc_start;
    logic hi_oc_trip;
    logic lo_ef_start;
    logic lo_ef_trip;
    logic hi_ef_trip;
  } psr_stage_type;

  typedef struct packed {
    logic main_trip;
    logic first_alarm_out;
    logic second_alarm_out;
    logic third_alarm_out;
    logic reclose_start_in_a;
    logic reclose_start_in_b;
    logic reclose_inhibit;
  } psr_route_type;

  typedef struct packed {
    logic [NUM_OBJECTS-1:0] open_out;
    logic [NUM_OBJECTS-1:0] close_out;
    logic                   fifth_alarm_out;
    logic                   sixth_alarm_out;
  } psr_object_type;

endpackage
`default_nettype wire

// ---- psr_routing.sv ----
// Overview of operation
// - object outputs use codes 20..31 open/close alternating, +200 direct; 40, 41 extra.
// - open and close of same index form one object pair.
// - some stage signals routed fixed, others only through routing switches.
// - routing bit 1 sends low-set overcurrent start to third alarm.
// - routing bit 2 sends both overcurrent trips to first alarm.
// - routing bit 3 sends low-set earth-fault trip to main trip.
// - bit 3 clear: that trip gives second alarm and reclose inhibit only.
// - routing bit 7 copies all main trip sources onto first alarm.
// - routing bit 8 copies all main trip sources onto second alarm.
// - first and second alarms may be delayed 40 ms.
// - reclose due suppresses first and second alarm outputs.
// - link bit 1 sends low-set overcurrent start to reclose start b.
// - link bit 2 sends high-set overcurrent start to reclose start b.
// - link bit 3 sends high-set overcurrent start to reclose start a.
// - link bits 4,5 let first block input stop low/high overcurrent trip.
// - link bits 6,7 let second block input stop low/high overcurrent trip.
`timescale 1ns/1ps
`default_nettype none
module psr_routing
  #(
    parameter int ALARM_DELAY = psr_pkg::ALARM_DELAY_CYCLES
  )
  (
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    input  wire psr_pkg::psr_stage_type STAGE,
    input  wire logic                 BLOCK_IN_FIRST,
    input  wire logic                 BLOCK_IN_SECOND,
    input  wire logic [7:0]           OUTPUT_ROUTING_SWITCHES,
    input  wire logic [7:0]           MODULE_LINK_SWITCHES,
    input  wire logic                 ALARM_DELAY_ENABLE,
    input  wire logic                 RECLOSE_DUE_FLAG,
    input  wire logic                 CMD_VALID,
    input  wire logic [7:0]           CMD_CODE,
    input  wire logic                 CMD_ON,
    output var  psr_pkg::psr_route_type  ROUTE,
    output var  psr_pkg::psr_object_type OBJECT,
    output var  logic                 CMD_DIRECT,
    output var  logic                 CMD_REJECT
  );
  import psr_pkg::*;

  // alarm rises exactly ALARM_DELAY edges after the undelayed one would
  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST = DELAY_CNT_W'(ALARM_DELAY);

  // stage, block and switch pins are asynchronous to CLK: two flops before any logic
  psr_stage_type stage_meta;
  psr_stage_type stage_sync;
  logic [1:0]    block_meta;
  logic [1:0]    block_sync;
  logic [7:0]    route_meta;
  logic [7:0]    route_sync;
  logic [7:0]    link_meta;
  logic [7:0]    link_sync;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      stage_meta <= '0;
      stage_sync <= '0;
      block_meta <= 2'h0;
      block_sync <= 2'h0;
      route_meta <= ROUTE_DEFAULT;
      route_sync <= ROUTE_DEFAULT;
      link_meta  <= LINK_DEFAULT;
      link_sync  <= LINK_DEFAULT;
    end
    else
    begin
      stage_meta <= STAGE;
      stage_sync <= stage_meta;
      block_meta <= {BLOCK_IN_SECOND, BLOCK_IN_FIRST};
      block_sync <= block_meta;
      route_meta <= OUTPUT_ROUTING_SWITCHES;
      route_sync <= route_meta;
      link_meta  <= MODULE_LINK_SWITCHES;
      link_sync  <= link_meta;
    end
  end

  // combinational routing matrix
  logic lo_oc_blocked;
  logic hi_oc_blocked;
  logic lo_oc_trip_ok;
  logic hi_oc_trip_ok;
  logic ef_to_trip;
  logic ef_signal_only;
  logic next_main_trip;
  logic next_third_alarm;
  logic next_start_a;
  logic next_start_b;
  logic next_inhibit;
  logic [1:0] alarm_raw;

  always_comb
  begin
    lo_oc_blocked = (block_sync[0] & link_sync[LINK_BLK1_LO_OC])
                  | (block_sync[1] & link_sync[LINK_BLK2_LO_OC]);
    hi_oc_blocked = (block_sync[0] & link_sync[LINK_BLK1_HI_OC])
                  | (block_sync[1] & link_sync[LINK_BLK2_HI_OC]);
    lo_oc_trip_ok = stage_sync.lo_oc_trip & ~lo_oc_blocked;
    hi_oc_trip_ok = stage_sync.hi_oc_trip & ~hi_oc_blocked;
    ef_to_trip     = stage_sync.lo_ef_trip & route_sync[ROUTE_LO_EF_TRIP_MAIN];
    ef_signal_only = stage_sync.lo_ef_trip & ~route_sync[ROUTE_LO_EF_TRIP_MAIN];
    // overcurrent trips and high-set earth-fault trip are hard wired to trip
    next_main_trip = lo_oc_trip_ok | hi_oc_trip_ok
                   | stage_sync.hi_ef_trip | ef_to_trip;
    next_third_alarm = stage_sync.lo_oc_start & route_sync[ROUTE_LO_OC_START_ALARM3];
    alarm_raw[0] = ((lo_oc_trip_ok | hi_oc_trip_ok)
                    & route_sync[ROUTE_OC_TRIP_ALARM1])
                 | (next_main_trip & route_sync[ROUTE_TRIP_TO_ALARM1]);
    alarm_raw[1] = ef_signal_only
                 | (next_main_trip & route_sync[ROUTE_TRIP_TO_ALARM2]);
    // both b sources may be on; only a/b conflict is forbidden to the configurer
    next_start_b = (stage_sync.lo_oc_start & link_sync[LINK_LO_OC_START_B])
                 | (stage_sync.hi_oc_start & link_sync[LINK_HI_OC_START_B]);
    next_start_a = stage_sync.hi_oc_start & link_sync[LINK_HI_OC_START_A];
    next_inhibit = ef_signal_only;
    // unused switch positions are simply never read
  end

  // one flop per destination; the output struct is only wiring of flops
  logic main_trip_q;
  logic third_alarm_q;
  logic start_a_q;
  logic start_b_q;
  logic inhibit_q;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      main_trip_q <= 1'b0;
    end
    else
    begin
      main_trip_q <= next_main_trip;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      third_alarm_q <= 1'b0;
    end
    else
    begin
      third_alarm_q <= next_third_alarm;
    end
  end

  // reclose starts stay level signals; the reclose logic latches due on their level while armed
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      start_a_q <= 1'b0;
      start_b_q <= 1'b0;
    end
    else
    begin
      start_a_q <= next_start_a;
      start_b_q <= next_start_b;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      inhibit_q <= 1'b0;
    end
    else
    begin
      inhibit_q <= next_inhibit;
    end
  end

  // alarm delay: a short trip that recloses never reaches the alarm contacts
  for (genvar i = 0; i < 2; i++)
  begin : g_alarm
    logic [DELAY_CNT_W-1:0] count;
    logic                   alarm_bit;

    always_ff @(posedge CLK or negedge RESETN)
    begin
      if (!RESETN)
      begin
        count     <= '0;
        alarm_bit <= 1'b0;
      end
      else if (!alarm_raw[i] || RECLOSE_DUE_FLAG)
      begin
        count     <= '0;
        alarm_bit <= 1'b0;
      end
      else if (!ALARM_DELAY_ENABLE)
      begin
        count     <= '0;
        alarm_bit <= 1'b1;
      end
      else if (count >= DELAY_LAST)
      begin
        alarm_bit <= 1'b1;
      end
      else
      begin
        count <= count + 1'b1;
      end
    end
  end

  // field order follows the route struct, msb first
  assign ROUTE = {main_trip_q, g_alarm[0].alarm_bit, g_alarm[1].alarm_bit, third_alarm_q,
                  start_a_q, start_b_q, inhibit_q};

  // object output commands
  logic [7:0] cfg_index;
  logic [7:0] dir_index;
  logic       cfg_hit;
  logic       dir_hit;
  logic [7:0] obj_code;
  logic       extra_hit;

  always_comb
  begin
    cfg_index = CMD_CODE - CODE_CFG_BASE;
    dir_index = CMD_CODE - CODE_CFG_BASE - CODE_DIRECT_OFS;
    cfg_hit   = (CMD_CODE >= CODE_CFG_BASE) && (cfg_index < CODE_SPAN);
    dir_hit   = (CMD_CODE >= (CODE_CFG_BASE + CODE_DIRECT_OFS))
              && (dir_index < CODE_SPAN);
    obj_code  = dir_hit ? dir_index : cfg_index;
    extra_hit = (CMD_CODE == CODE_FIFTH) || (CMD_CODE == CODE_SIXTH);
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      OBJECT     <= '0;
      CMD_DIRECT <= 1'b0;
      CMD_REJECT <= 1'b0;
    end
    else
    begin
      CMD_REJECT <= 1'b0;
      if (CMD_VALID)
      begin
        if (cfg_hit || dir_hit)
        begin
          CMD_DIRECT <= dir_hit;
          // even code opens, odd code closes object code/2
          if (!obj_code[0])
          begin
            OBJECT.open_out[obj_code[3:1]] <= CMD_ON;
            if (CMD_ON)
            begin
              OBJECT.close_out[obj_code[3:1]] <= 1'b0;
            end
          end
          else
          begin
            OBJECT.close_out[obj_code[3:1]] <= CMD_ON;
            if (CMD_ON)
            begin
              OBJECT.open_out[obj_code[3:1]] <= 1'b0;
            end
          end
        end
        else if (extra_hit)
        begin
          CMD_DIRECT <= 1'b0;
          if (CMD_CODE == CODE_FIFTH)
          begin
            OBJECT.fifth_alarm_out <= CMD_ON;
          end
          else
          begin
            OBJECT.sixth_alarm_out <= CMD_ON;
          end
        end
        else
        begin
          CMD_REJECT <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- psr_routing_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_routing_monitor
  #(parameter int ALARM_DELAY = 20)
  (
  input wire logic                    CLK,
  input wire logic                    RESETN,
  input wire psr_pkg::psr_stage_type  STAGE,
  input wire logic                    BLOCK_IN_FIRST,
  input wire logic                    BLOCK_IN_SECOND,
  input wire logic [7:0]              OUTPUT_ROUTING_SWITCHES,
  input wire logic [7:0]              MODULE_LINK_SWITCHES,
  input wire logic                    ALARM_DELAY_ENABLE,
  input wire logic                    RECLOSE_DUE_FLAG,
  input wire logic                    CMD_VALID,
  input wire logic [7:0]              CMD_CODE,
  input wire logic                    CMD_ON,
  input wire psr_pkg::psr_route_type  ROUTE,
  input wire psr_pkg::psr_object_type OBJECT,
  input wire logic                    CMD_DIRECT,
  input wire logic                    CMD_REJECT
  );
  import psr_pkg::*;
  wire logic [7:0] rs  = OUTPUT_ROUTING_SWITCHES;
  wire logic [7:0] ls  = MODULE_LINK_SWITCHES;
  wire logic       oc  = (STAGE.lo_oc_trip & ~(BLOCK_IN_FIRST & ls[3]) & ~(BLOCK_IN_SECOND & ls[5]))
    | (STAGE.hi_oc_trip & ~(BLOCK_IN_FIRST & ls[4]) & ~(BLOCK_IN_SECOND & ls[6]));
  wire logic       trp = oc | STAGE.hi_ef_trip | (STAGE.lo_ef_trip & rs[2]);
  wire logic       inh = STAGE.lo_ef_trip & ~rs[2];
  wire logic       al1 = (oc & rs[1]) | (trp & rs[6]);
  wire logic [1:0] als = {al1, (trp & rs[7]) | inh};
  wire logic [1:0] ars = {STAGE.hi_oc_start & ls[2],
    (STAGE.lo_oc_start & ls[0]) | (STAGE.hi_oc_start & ls[1])};
  wire logic       cfg = CMD_CODE >= 8'h14 && CMD_CODE <= 8'h1f;
  wire logic       dir = CMD_CODE >= 8'hdc && CMD_CODE <= 8'he7;
  wire logic       bad = ~cfg & ~dir & CMD_CODE != 8'h28 & CMD_CODE != 8'h29;
  wire logic [3:0] ofs = 4'(CMD_CODE - (dir ? 8'hdc : 8'h14));
  wire logic [5:0] hot = 6'h01 << ofs[3:1];
  wire logic       cls = ofs[0];
  wire logic       tke = CMD_VALID & CMD_ON & (cfg | dir);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // alarm compare only while neither delay nor due can mask the source
  sequence quiet;
    (!ALARM_DELAY_ENABLE && !RECLOSE_DUE_FLAG)[*4];
  endsequence
  third_alarm_a:
    assert property ($past(RESETN, 5) |-> ROUTE.third_alarm_out == $past(ars[1] & 1'b0 | STAGE.lo_oc_start & rs[0], 3)) else $error("third alarm");
  reclose_start_a:
    assert property ($past(RESETN, 5) |-> {ROUTE.reclose_start_in_a, ROUTE.reclose_start_in_b} == $past(ars, 3)) else $error("reclose start");
  main_trip_a:
    assert property ($past(RESETN, 5) |-> ROUTE.main_trip == $past(trp, 3)) else $error("main trip");
  ef_inhibit_a:
    assert property ($past(RESETN, 5) |-> ROUTE.reclose_inhibit == $past(inh, 3)) else $error("inhibit");
  alarm_pair_a:
    assert property (quiet ##0 $past(RESETN, 5) |-> {ROUTE.first_alarm_out, ROUTE.second_alarm_out} == $past(als, 3)) else $error("alarms");
  due_clear_a:
    assert property (RECLOSE_DUE_FLAG |=> !ROUTE.first_alarm_out && !ROUTE.second_alarm_out) else $error("due");
  alarm_delay_a:
    assert property ($rose(ROUTE.first_alarm_out) && ALARM_DELAY_ENABLE |-> $past(al1, ALARM_DELAY)) else $error("delay");
  cmd_reject_a:
    assert property (CMD_VALID |=> CMD_REJECT == $past(bad)) else $error("reject");
  object_pair_a:
    assert property (tke |=> ((OBJECT.open_out & $past(hot)) != 6'h00) != $past(cls)
      && ((OBJECT.close_out & $past(hot)) != 6'h00) == $past(cls) && CMD_DIRECT == $past(dir)) else $error("object");
endmodule
bind psr_routing psr_routing_monitor #(.ALARM_DELAY(ALARM_DELAY)) mon (.*);
`default_nettype wire

// ---- psr_routing_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_routing_test;
  import psr_pkg::*;
  localparam int          DLY = 20;
  localparam logic [17:0] CFG [3] = '{{8'h07, 8'h05, 2'h0}, {8'hc3, 8'h7a, 2'h3}, {8'h80, 8'h54, 2'h2}};
  localparam logic [7:0]  BAD [4] = '{8'h13, 8'h20, 8'hdb, 8'he8};
  logic           clk       = 1'b0;
  logic           resetn    = 1'b0;
  logic           blk1      = 1'b0;
  logic           blk2      = 1'b0;
  logic           dly_en    = 1'b0;
  logic           arm       = 1'b0;
  logic           cmd_valid = 1'b0;
  logic           cmd_on    = 1'b0;
  logic [7:0]     code      = 8'h00;
  logic [7:0]     rsw       = ROUTE_DEFAULT;
  logic [7:0]     lsw       = LINK_DEFAULT;
  logic [13:0]    exp_obj   = 14'h0000;
  psr_stage_type  fault     = '0;
  psr_stage_type  stage;
  psr_route_type  route;
  psr_object_type object;
  logic           due;
  logic           direct;
  logic           reject;
  int             errors    = 0;
  int             tests_run = 0;
  int             cycles    = 0;
  psr_far_end far (.CLK(clk), .RESETN(resetn), .ARM(arm), .FAULT(fault), .ROUTE(route),
    .STAGE(stage), .DUE(due));
  psr_routing #(.ALARM_DELAY(DLY)) DUT (.CLK(clk), .RESETN(resetn), .STAGE(stage),
    .BLOCK_IN_FIRST(blk1), .BLOCK_IN_SECOND(blk2), .OUTPUT_ROUTING_SWITCHES(rsw),
    .MODULE_LINK_SWITCHES(lsw), .ALARM_DELAY_ENABLE(dly_en), .RECLOSE_DUE_FLAG(due),
    .CMD_VALID(cmd_valid), .CMD_CODE(code), .CMD_ON(cmd_on), .ROUTE(route),
    .OBJECT(object), .CMD_DIRECT(direct), .CMD_REJECT(reject));
  always #2.5 clk = ~clk;
  // whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic psr_route_type model(input psr_stage_type s);
    logic          o;
    logic          t;
    psr_route_type r;
    o = (s.lo_oc_trip & ~(blk1 & lsw[3]) & ~(blk2 & lsw[5]))
      | (s.hi_oc_trip & ~(blk1 & lsw[4]) & ~(blk2 & lsw[6]));
    t = o | s.hi_ef_trip | (s.lo_ef_trip & rsw[2]);
    r = {t, (o & rsw[1]) | (t & rsw[6]), (t & rsw[7]) | (s.lo_ef_trip & ~rsw[2]),
      s.lo_oc_start & rsw[0], s.hi_oc_start & lsw[2],
      (s.lo_oc_start & lsw[0]) | (s.hi_oc_start & lsw[1]), s.lo_ef_trip & ~rsw[2]};
    return r;
  endfunction
  task automatic routing_matrix();
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 8; j++)
      begin
        @(posedge clk);
        {rsw, lsw, blk1, blk2} <= CFG[i];
        fault <= (j == 7) ? 7'h7f : 7'(1 << j);
        repeat (6) @(posedge clk);
        #1 check("route", 16'(model(fault)), 16'(route));
      end
  endtask
  task automatic delay_and_due();
    @(posedge clk);
    {rsw, lsw, blk1, blk2} <= CFG[0];
    fault <= '0;
    dly_en <= 1'b1;
    repeat (6) @(posedge clk);
    fault <= 7'h60;
    repeat (DLY) @(posedge clk);
    #1 check("early alarm", 16'h0000, 16'(route.first_alarm_out));
    check("trip", 16'h0001, 16'(route.main_trip));
    repeat (8) @(posedge clk);
    #1 check("late alarm", 16'h0001, 16'(route.first_alarm_out));
    @(posedge clk);
    arm <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("due alarm", 16'h0000, 16'(route.first_alarm_out));
    @(posedge clk);
    fault <= '0;
    repeat (6) @(posedge clk);
    arm <= 1'b0;
    dly_en <= 1'b0;
  endtask
  task automatic send(input logic [7:0] c, input logic on);
    @(posedge clk);
    cmd_valid <= 1'b1;
    code <= c;
    cmd_on <= on;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic commands();
    for (int k = 0; k < 24; k++)
    begin
      send(8'(k < 12 ? 20 + k : 208 + k), 1'b1);
      exp_obj[8 + (k % 12) / 2] = ~k[0];
      exp_obj[2 + (k % 12) / 2] = k[0];
      check("objects", 16'(exp_obj), 16'(object));
      check("direct", 16'(k >= 12), 16'(direct));
    end
    send(CODE_FIFTH, 1'b1);
    send(CODE_SIXTH, 1'b1);
    send(CODE_SIXTH, 1'b0);
    exp_obj[1] = 1'b1;
    check("objects", 16'(exp_obj), 16'(object));
    send(8'h1f, 1'b0);
    exp_obj[7] = 1'b0;
    check("release", 16'(exp_obj), 16'(object));
    check("direct", 16'h0000, 16'(direct));
    foreach (BAD[i])
    begin
      send(BAD[i], 1'b1);
      check("reject", 16'h0001, 16'(reject));
      check("objects", 16'(exp_obj), 16'(object));
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    routing_matrix();
    delay_and_due();
    commands();
    complete_run();
  end
endmodule
`default_nettype wire
